// *** gp1_pin_ctrl.sv ***
// Purpose: pin one control register, pin output mux, clock divider and interrupt pulser
// Assumes: AXI4-Lite slave, one transfer of each direction at a time
// Notes: pin, clock and input levels are asynchronous and pass two flip-flops
`timescale 1ns/1ps
`include "gp1_regs.svh"
module gp1_pin_ctrl
  import gp1_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `GP1_PULSE_NS / `GP1_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // clock sources, sampled as levels
  input  wire logic        pll_clk,
  input  wire logic        div_mux_clk,
  // interrupt sources on aclk
  input  wire logic        headset_det,
  input  wire logic        button_press,
  input  wire logic        short_circuit,
  input  wire logic        agc_noise,
  // pin
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe,
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: {div mux clock, pll clock, pin}
  logic [2:0] sy_m;
  logic [2:0] sy_s;
  logic [2:0] sy_q;
  always_ff @(posedge aclk) begin
    sy_m <= aresetn ? {div_mux_clk, pll_clk, pin_in} : 3'h0;
    sy_s <= aresetn ? sy_m : 3'h0;
    sy_q <= aresetn ? sy_s : 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  gp1_ctrl_s   ctrl;
  logic [2:0]  status;
  logic [2:0]  mask;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  gp1_pstate_e pstate;
  logic [17:0] pcnt;
  logic [2:0]  div_cnt;
  logic        src_q;
  logic        pulse;

  wire logic pin_s   = sy_s[0];
  wire logic clk_s   = sy_s[1 + ctrl.clk_sel];
  wire logic clk_q   = sy_q[1 + ctrl.clk_sel];
  wire logic clk_ris = clk_s & ~clk_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic do_write = aw_held & w_held & ~bvalid;
  wire logic rd_take  = arvalid & arready;
  wire logic wr_ctrl  = do_write & (aw_addr == `GP1_OFF_CTRL) & w_strb[0];
  wire logic wr_stat  = do_write & (aw_addr == `GP1_OFF_STATUS) & w_strb[0];
  wire logic wr_mask  = do_write & (aw_addr == `GP1_OFF_MASK) & w_strb[0];
  wire logic wr_hit   = (aw_addr == `GP1_OFF_CTRL) | (aw_addr == `GP1_OFF_STATUS)
                      | (aw_addr == `GP1_OFF_MASK) | (aw_addr == `GP1_OFF_FLAGS);
  wire logic rd_hit   = (araddr == `GP1_OFF_CTRL) | (araddr == `GP1_OFF_STATUS)
                      | (araddr == `GP1_OFF_MASK) | (araddr == `GP1_OFF_FLAGS);
  wire logic rd_flags = rd_take & (araddr == `GP1_OFF_FLAGS);
  wire logic [3:0] flags = {agc_noise, short_circuit, button_press, headset_det};
  wire logic [7:0] ctrl_rd = {ctrl.out_ctl, ctrl.clk_sel, ctrl.dur_rep, pin_s,
                              ctrl.out_val};
  wire logic [31:0] next_rdata =
      (araddr == `GP1_OFF_CTRL)   ? {24'h0, ctrl_rd} :
      (araddr == `GP1_OFF_STATUS) ? {29'h0, status} :
      (araddr == `GP1_OFF_MASK)   ? {29'h0, mask} :
      (araddr == `GP1_OFF_FLAGS)  ? {28'h0, flags} : 32'h0;

  assign awready = ~aw_held;
  assign wready  = ~w_held;
  assign arready = ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (awvalid & awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (wvalid & wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `GP1_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? `GP1_RESP_OKAY : `GP1_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `GP1_RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= rd_hit ? `GP1_RESP_OKAY : `GP1_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // input level bit is never stored; the read returns the live pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= gp1_ctrl_s'(`GP1_RST_CTRL);
    end else if (wr_ctrl) begin
      ctrl.out_ctl <= w_data[7:4];
      ctrl.clk_sel <= w_data[`GP1_BIT_CLK_SEL];
      ctrl.dur_rep <= w_data[`GP1_BIT_DUR_REP];
      ctrl.out_val <= w_data[`GP1_BIT_OUT_VAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and interrupt source selection
  wire logic [3:0] mode   = ctrl.out_ctl;
  wire logic is_clk = (mode == GP1_DIV1) | (mode == GP1_DIV2)
                    | (mode == GP1_DIV4) | (mode == GP1_DIV8);
  wire logic is_int = (mode == GP1_SHORT) | (mode == GP1_BUTTON) | (mode == GP1_HEAD)
                    | (mode == GP1_HD_BTN) | (mode == GP1_ANY);
  wire logic is_gpo = (mode == GP1_GPO);
  wire logic src_sel =
      (mode == GP1_SHORT)  ? short_circuit :
      (mode == GP1_BUTTON) ? button_press :
      (mode == GP1_HEAD)   ? headset_det :
      (mode == GP1_HD_BTN) ? (headset_det | button_press) :
      (mode == GP1_ANY)    ? (|flags) : 1'b0;
  wire logic src_ev   = is_int & src_sel & ~src_q;
  wire logic div_sel  =
      (mode == GP1_DIV1) ? clk_s :
      (mode == GP1_DIV2) ? div_cnt[0] :
      (mode == GP1_DIV4) ? div_cnt[1] : div_cnt[2];
  wire logic next_pin_oe  = is_gpo | is_clk | is_int;
  wire logic next_pin_out = is_gpo ? ctrl.out_val : is_clk ? div_sel :
                            is_int ? pulse : 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 3'h0;
      src_q   <= 1'b0;
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      div_cnt <= clk_ris ? div_cnt + 3'h1 : div_cnt;
      src_q   <= src_sel;
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pulser: high and low phases are both one pulse length
  wire logic pdone = (pcnt == 18'h0);
  wire logic stop  = ctrl.dur_rep & rd_flags;
  assign pulse = (pstate == GP1_HIGH);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pstate <= GP1_IDLE;
      pcnt   <= 18'h0;
    end else begin
      unique case (pstate)
        GP1_IDLE: begin
          if (src_ev) begin
            pstate <= GP1_HIGH;
            pcnt   <= 18'(PULSE_CYC - 1);
          end
        end
        GP1_HIGH: begin
          if (stop) begin
            pstate <= GP1_IDLE;
          end else if (pdone) begin
            pstate <= ctrl.dur_rep ? GP1_LOW : GP1_IDLE;
            pcnt   <= 18'(PULSE_CYC - 1);
          end else begin
            pcnt <= pcnt - 18'h1;
          end
        end
        GP1_LOW: begin
          if (stop || !ctrl.dur_rep) begin
            pstate <= GP1_IDLE;
          end else if (pdone) begin
            pstate <= GP1_HIGH;
            pcnt   <= 18'(PULSE_CYC - 1);
          end else begin
            pcnt <= pcnt - 18'h1;
          end
        end
        default: pstate <= GP1_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, set wins over write-one-to-clear
  wire logic [2:0] ev_set = {~pin_s & sy_q[0], pin_s & ~sy_q[0],
                             (pstate == GP1_IDLE) & src_ev};
  wire logic [2:0] ev_clr = wr_stat ? w_data[2:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= `GP1_RST_STATUS;
      mask   <= `GP1_RST_MASK;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~ev_clr) | ev_set;
      mask   <= wr_mask ? w_data[2:0] : mask;
      irq    <= |(((status & ~ev_clr) | ev_set) & (wr_mask ? w_data[2:0] : mask));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [17:0] hi_len;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_len <= 18'h0;
    end else begin
      hi_len <= pulse ? hi_len + 18'h1 : 18'h0;
    end
  end

  clk_source_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(mode) == GP1_DIV1 && mode == GP1_DIV1)
      |-> pin_out == $past(ctrl.clk_sel ? sy_s[2] : sy_s[1]))
    else $error("pin clock not from selected source");
  single_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(pulse) && !ctrl.dur_rep && !$past(stop)) |-> hi_len == 18'(PULSE_CYC))
    else $error("single pulse length wrong");
  repeat_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (stop && pstate != GP1_IDLE) |=> pstate == GP1_IDLE ##1 !pulse)
    else $error("pulses did not stop on flags read");
  input_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_take && araddr == `GP1_OFF_CTRL) |=> rdata[1] == $past(pin_s))
    else $error("input level bit wrong");
  output_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(is_gpo) |-> (pin_oe && pin_out == $past(ctrl.out_val)))
    else $error("output level not driven");
  pin_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == GP1_GPI || mode == GP1_OFF) |=> !pin_oe)
    else $error("pin driven in input or off mode");
  clk_divide_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == GP1_DIV4) |=> pin_out == $past(div_cnt[1]))
    else $error("divide by four wrong");
  or_source_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == GP1_ANY && $past(mode) == GP1_ANY && pstate == GP1_IDLE
      && !$past(headset_det | button_press | short_circuit | agc_noise)
      && (headset_det | button_press | short_circuit | agc_noise)) |=> pulse)
    else $error("interrupt source or wrong");
  read_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && !rready) |=> (rvalid && $stable(rdata)))
    else $error("read answer dropped");

  pulse_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) $fell(pulse));
  repeat_c: cover property (@(posedge aclk) disable iff (!aresetn)
    pstate == GP1_LOW ##1 pstate == GP1_HIGH);
  write_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_ctrl);
  irq_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

endmodule : gp1_pin_ctrl

// *** gp1_pin_ctrl_test.sv ***
// Purpose: self-checking bench for the pin one control block
// Assumes: pulse length shortened to 8 cycles
// Notes: registers over AXI4-Lite, pin side from the partner model
`timescale 1ns/1ps
`include "gp1_regs.svh"
module gp1_pin_ctrl_test;
  import gp1_pkg::*;
  localparam int PULSE = 8;
  logic        aclk = 1'h0, aresetn = 1'h0, ext_level = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF, src = 4'h0;
  logic [1:0]  bresp, rresp;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pll_clk, div_mux_clk, pin_in, pin_out, pin_oe, irq;
  int          bad_count = 0, checks = 0;

  gp1_pin_ctrl #(.PULSE_CYC(PULSE)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pll_clk(pll_clk), .div_mux_clk(div_mux_clk),
    .headset_det(src[0]), .button_press(src[1]), .short_circuit(src[2]), .agc_noise(src[3]),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq)
  );
  gp1_pin_partner u_far (
    .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pll_clk(pll_clk), .div_mux_clk(div_mux_clk), .pin_in(pin_in)
  );

  initial forever #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic near(input int a, input int b);
    chk({31'h0, (a - b <= 1) && (b - a <= 1)}, 32'h1);
  endtask : near

  // one idle edge first so no strobe is driven twice in one time step
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        done = 1'h1;
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
      end
    end
    chk({31'h0, done}, 32'h1);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        done = 1'h1;
        rready <= 1'h0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
    chk({31'h0, done}, 32'h1);
  endtask : axr

  task automatic watch(input int n, output int hi, output int rises);
    logic last;
    hi = 0;
    rises = 0;
    last = pin_out;
    repeat (n) begin
      @(posedge aclk);
      hi += (pin_out === 1'h1);
      rises += (pin_out === 1'h1 && last !== 1'h1);
      last = pin_out;
    end
  endtask : watch

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    axr(`GP1_OFF_CTRL, 32'h0, `GP1_RESP_OKAY);
    axr(`GP1_OFF_STATUS, 32'h0, `GP1_RESP_OKAY);
    axr(`GP1_OFF_MASK, 32'h0, `GP1_RESP_OKAY);
    axr(8'h10, 32'h0, `GP1_RESP_SLVERR);
    axw(8'h10, 32'hFF, `GP1_RESP_SLVERR);
  endtask : t_reset

  task automatic t_gpo;
    logic [7:0] code [4] = '{8'h91, 8'h90, 8'h81, 8'h01};
    logic [1:0] want [4] = '{2'h3, 2'h2, 2'h0, 2'h0};
    foreach (code[i]) begin
      axw(`GP1_OFF_CTRL, {24'h0, code[i]}, `GP1_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({30'h0, pin_oe, pin_oe & pin_out}, {30'h0, want[i]});
    end
    axr(`GP1_OFF_CTRL, 32'h01, `GP1_RESP_OKAY);
  endtask : t_gpo

  task automatic t_input;
    axw(`GP1_OFF_CTRL, 32'h80, `GP1_RESP_OKAY);
    ext_level <= 1'h1;
    repeat (4) @(posedge aclk);
    axr(`GP1_OFF_CTRL, 32'h82, `GP1_RESP_OKAY);
    ext_level <= 1'h0;
    repeat (4) @(posedge aclk);
    axr(`GP1_OFF_CTRL, 32'h80, `GP1_RESP_OKAY);
    axr(`GP1_OFF_STATUS, 32'h6, `GP1_RESP_OKAY);
    axw(`GP1_OFF_STATUS, 32'h6, `GP1_RESP_OKAY);
    axr(`GP1_OFF_STATUS, 32'h0, `GP1_RESP_OKAY);
  endtask : t_input

  task automatic t_clock;
    logic [7:0] code [5] = '{8'h20, 8'h30, 8'h40, 8'h50, 8'h28};
    int         want [5] = '{32, 16, 8, 4, 16};
    int         hi, rises;
    foreach (code[i]) begin
      axw(`GP1_OFF_CTRL, {24'h0, code[i]}, `GP1_RESP_OKAY);
      repeat (8) @(posedge aclk);
      watch(256, hi, rises);
      near(rises, want[i]);
    end
  endtask : t_clock

  task automatic t_single;
    int hi, rises;
    axw(`GP1_OFF_MASK, 32'h1, `GP1_RESP_OKAY);
    axw(`GP1_OFF_CTRL, 32'h60, `GP1_RESP_OKAY);
    src <= 4'h4;
    watch(30, hi, rises);
    chk(hi, PULSE);
    chk(rises, 1);
    chk({31'h0, irq}, 32'h1);
    src <= 4'h0;
    axw(`GP1_OFF_MASK, 32'h0, `GP1_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    // pin edges from the clock modes and from this pulse are latched too
    axr(`GP1_OFF_STATUS, 32'h7, `GP1_RESP_OKAY);
    axw(`GP1_OFF_STATUS, 32'h7, `GP1_RESP_OKAY);
    axr(`GP1_OFF_STATUS, 32'h0, `GP1_RESP_OKAY);
  endtask : t_single

  task automatic t_repeat;
    int hi, rises;
    axw(`GP1_OFF_CTRL, 32'h64, `GP1_RESP_OKAY);
    src <= 4'h4;
    watch(64, hi, rises);
    near(hi, 4 * PULSE);
    chk(rises, 4);
    axr(`GP1_OFF_FLAGS, 32'h4, `GP1_RESP_OKAY);
    src <= 4'h0;
    repeat (3) @(posedge aclk);
    watch(40, hi, rises);
    chk(hi, 0);
  endtask : t_repeat

  task automatic t_or;
    int hi, rises;
    axw(`GP1_OFF_CTRL, 32'hF0, `GP1_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      src <= 4'h1 << i;
      watch(20, hi, rises);
      chk(hi, PULSE);
      src <= 4'h0;
      repeat (2) @(posedge aclk);
    end
  endtask : t_or

  // the button, headset and headset-or-button selections must fire only on their own sources
  task automatic t_select;
    logic [7:0] code [3] = '{8'hC0, 8'hD0, 8'hE0};
    logic [2:0] fire [3] = '{3'b010, 3'b001, 3'b011};
    int         hi, rises;
    foreach (code[i]) begin
      axw(`GP1_OFF_CTRL, {24'h0, code[i]}, `GP1_RESP_OKAY);
      for (int j = 0; j < 3; j++) begin
        src <= 4'h1 << j;
        watch(20, hi, rises);
        chk(hi, fire[i][j] ? PULSE : 0);
        src <= 4'h0;
        repeat (2) @(posedge aclk);
      end
    end
  endtask : t_select

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_gpo();
    t_input();
    t_clock();
    t_single();
    t_repeat();
    t_or();
    t_select();
    stop_test();
  end

  // the run needs about 2000 cycles; this allows for a stuck handshake
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule : gp1_pin_ctrl_test

// *** gp1_pin_partner.sv ***
// Purpose: far side of pin one: free running clock sources and the pin wire
// Assumes: both sources run free and slower than aclk
// Notes: the host side drives the wire whenever the device lets go
`timescale 1ns/1ps
module gp1_pin_partner (
  // from the device
  input  wire logic aclk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // level the host side drives
  input  wire logic ext_level,
  // to the device
  output logic      pll_clk,
  output logic      div_mux_clk,
  output logic      pin_in
);
  logic [7:0] ticks = 8'h00;
  always @(posedge aclk) ticks <= ticks + 8'h01;
  // periods of 8 and 16 cycles so the two sources are easy to tell apart
  assign pll_clk     = ticks[2];
  assign div_mux_clk = ticks[3];
  assign pin_in      = pin_oe ? pin_out : ext_level;
endmodule : gp1_pin_partner

// *** gp1_pkg.sv ***
// Purpose: types shared by the pin one control block
// Assumes: nothing beyond the register header
// Notes: control byte layout follows the register bit order
package gp1_pkg;
  typedef struct packed {
    logic [3:0] out_ctl;
    logic       clk_sel;
    logic       dur_rep;
    logic       in_val;
    logic       out_val;
  } gp1_ctrl_s;

  typedef enum logic [3:0] {
    GP1_OFF    = 4'h0,
    GP1_DIV1   = 4'h2,
    GP1_DIV2   = 4'h3,
    GP1_DIV4   = 4'h4,
    GP1_DIV8   = 4'h5,
    GP1_SHORT  = 4'h6,
    GP1_GPI    = 4'h8,
    GP1_GPO    = 4'h9,
    GP1_BUTTON = 4'hC,
    GP1_HEAD   = 4'hD,
    GP1_HD_BTN = 4'hE,
    GP1_ANY    = 4'hF
  } gp1_mode_e;

  typedef enum logic [1:0] {
    GP1_IDLE = 2'b00,
    GP1_HIGH = 2'b01,
    GP1_LOW  = 2'b10
  } gp1_pstate_e;
endpackage : gp1_pkg

// *** gp1_regs.svh ***
// Purpose: offsets, field positions, reset values and timing for the pin one control block
// Assumes: 100 MHz aclk, byte addresses on a 32-bit AXI4-Lite bus
// Notes: definitions only
// Contract
// - control bit 3 picks the pin clock source: 0 PLL, 1 divider mux.
// - duration bit 2 clear: each interrupt is one high pulse of about 2 ms.
// - duration bit 2 set: pulses repeat until the host reads the flags register.
// - bit 1 is read-only and returns the pin's current input level.
// - bit 0 is writable and sets the level driven in output mode.
// - output control 1000 is input mode, 1001 output mode, 0000 disabled.
// - codes 0010 to 0101 drive the selected clock divided by 1, 2, 4, 8.
// - code 1111 drives headset OR button OR short-circuit OR AGC-noise interrupt.
`ifndef GP1_REGS_SVH
`define GP1_REGS_SVH
`define GP1_OFF_CTRL      8'h00
`define GP1_OFF_STATUS    8'h04
`define GP1_OFF_MASK      8'h08
`define GP1_OFF_FLAGS     8'h0C
`define GP1_RST_CTRL      8'h00
`define GP1_RST_STATUS    3'h0
`define GP1_RST_MASK      3'h0
`define GP1_BIT_CLK_SEL   3
`define GP1_BIT_DUR_REP   2
`define GP1_BIT_IN_VAL    1
`define GP1_BIT_OUT_VAL   0
`define GP1_EV_PULSE      0
`define GP1_EV_IN_RISE    1
`define GP1_EV_IN_FALL    2
`define GP1_CLK_PERIOD_NS 10
`define GP1_PULSE_NS      2000000
`define GP1_RESP_OKAY     2'h0
`define GP1_RESP_SLVERR   2'h2
`endif
